// >>> rtl/tmpc_consts.vh
// constants for the timer prescaler, clock select and flag block
`ifndef TMPC_CONSTS_VH
`define TMPC_CONSTS_VH

`define TMPC_ADDR_W 4
`define TMPC_DATA_W 8

`define TMPC_REG_FLAGS 4'h0
`define TMPC_REG_MASK 4'h1
`define TMPC_REG_SYNC 4'h2
`define TMPC_REG_CLKSEL0 4'h3
`define TMPC_REG_CLKSEL1 4'h4
`define TMPC_REG_WAVE 4'h5
`define TMPC_REG_PRESCALE 4'h6

`define TMPC_BIT_CAPTURE 5
`define TMPC_BIT_CMPB 2
`define TMPC_BIT_CMPA 1
`define TMPC_BIT_OVF 0
`define TMPC_BIT_SYNCMODE 7
`define TMPC_BIT_PSR 0

`define TMPC_RST_BYTE 8'h00
`define TMPC_RST_FLAGS 4'h0
`define TMPC_RST_CLKSEL 3'h0
`define TMPC_RST_WAVE 4'h0
`define TMPC_RST_PRESCALE 10'h000

`define TMPC_CS_STOP 3'h0
`define TMPC_CS_DIRECT 3'h1
`define TMPC_CS_DIV8 3'h2
`define TMPC_CS_DIV64 3'h3
`define TMPC_CS_DIV256 3'h4
`define TMPC_CS_DIV1024 3'h5
`define TMPC_CS_EXT_FALL 3'h6
`define TMPC_CS_EXT_RISE 3'h7

`define TMPC_PRESCALE_W 10
`define TMPC_TAP8_BITS 3
`define TMPC_TAP64_BITS 6
`define TMPC_TAP256_BITS 8
`define TMPC_TAP1024_BITS 10

`define TMPC_WAVE_NORMAL 4'h0
`define TMPC_WAVE_CTC_CMP 4'h4
`define TMPC_WAVE_CTC_CAP 4'hc
`define TMPC_WAVE_PFC_CAP 4'h8
`define TMPC_WAVE_PC_CAP 4'ha
`define TMPC_WAVE_FAST_CAP 4'he

`endif

// >>> rtl/tmpc_pin_edge.v
// external clock pin synchroniser and edge detector
`timescale 1ns/1ps
module tmpc_pin_edge (
   input wire sys_clk,
   input wire sys_rst,
   input wire pinIn,
   output wire edgeRise,
   output wire edgeFall
);
   reg syncA_ff;
   reg syncB_ff;
   reg prev_ff;

   // RL11: two stage sampling
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         syncA_ff <= 1'b0;
         syncB_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         syncA_ff <= pinIn;
         syncB_ff <= syncA_ff;
         prev_ff <= syncB_ff;
      end
   end

   // RL12: one pulse per edge
   assign edgeRise = syncB_ff & ~prev_ff;
   assign edgeFall = ~syncB_ff & prev_ff;
endmodule

// >>> rtl/tmpc_clock_select.v
// per-timer clock source selector
`timescale 1ns/1ps
`include "tmpc_consts.vh"
module tmpc_clock_select (
   input wire sys_clk,
   input wire sys_rst,
   input wire [2:0] clockSelect,
   input wire [3:0] prescaleTap,
   input wire extRise,
   input wire extFall,
   input wire halt,
   output wire timerTick
);
   reg tick_ff;
   reg nxt_tick;

   always @* begin
      case (clockSelect)
         // RL20: no source
         `TMPC_CS_STOP: begin
            nxt_tick = 1'b0;
         end
         // RL7: direct system clock
         `TMPC_CS_DIRECT: begin
            nxt_tick = 1'b1;
         end
         // RL8: prescaler taps
         `TMPC_CS_DIV8: begin
            nxt_tick = prescaleTap[0];
         end
         `TMPC_CS_DIV64: begin
            nxt_tick = prescaleTap[1];
         end
         `TMPC_CS_DIV256: begin
            nxt_tick = prescaleTap[2];
         end
         `TMPC_CS_DIV1024: begin
            nxt_tick = prescaleTap[3];
         end
         // RL16: edges counted unprescaled
         `TMPC_CS_EXT_FALL: begin
            nxt_tick = extFall;
         end
         `TMPC_CS_EXT_RISE: begin
            nxt_tick = extRise;
         end
         default: begin
            nxt_tick = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= nxt_tick & ~halt;
      end
   end

   assign timerTick = tick_ff;
endmodule

// >>> rtl/tmpc_top.v
// shared prescaler, timer clock selection and timer1 event flags
//
// How it works
// RL1: capture flag sets on capture event, or at top when capture register is top.
// RL2: each flag clears on its vector acknowledge or on writing one.
// RL3: compare flags set in the timer cycle after counter equals compare.
// RL4: forced compare strobes never set compare flags.
// RL5: overflow flag follows waveform mode; normal and clear-on-compare use overflow.
// RL6: software writes zero to reserved flag bits 7, 6, 4, 3.
// RL7: clock select 1 ticks the timer every system clock.
// RL8: clock select 2 to 5 use taps dividing by 8, 64, 256, 1024.
// RL9: prescaler free running, shared, each timer has own clock select.
// RL10: first prescaled count lands 1 to N+1 cycles after enabling.
// RL11: external pin sampled every system clock through a synchroniser.
// RL12: select 7 counts rising edges, select 6 counts falling edges.
// RL13: external edge reaches the counter about three cycles later.
// RL14: software switches external clock only while pin is stable.
// RL15: external clock half period longer than one system clock.
// RL16: external clock never passes through the prescaler.
// RL17: sync mode keeps the written prescaler reset bit.
// RL18: writing sync mode zero clears prescaler reset, timers resume.
// RL19: prescaler reset bit holds prescaler reset, then self clears.
// RL20: clock select zero stops the timer.
// RL21: interrupt request when flag, mask bit and global enable all set.
// RL22: writing zero to a flag bit leaves it unchanged.
`timescale 1ns/1ps
`include "tmpc_consts.vh"
module tmpc_top (
   input wire sys_clk,
   input wire sys_rst,
   input wire [`TMPC_ADDR_W-1:0] regAddr,
   input wire [`TMPC_DATA_W-1:0] regWrData,
   input wire regWrEn,
   input wire regRdEn,
   output wire [`TMPC_DATA_W-1:0] regRdData,
   input wire extClkPin0,
   input wire extClkPin1,
   input wire captureEvent,
   input wire compareAEqual,
   input wire compareBEqual,
   input wire counterAtMax,
   input wire counterAtTop,
   input wire counterAtBottom,
   input wire [3:0] vectorAck,
   input wire globalIntEnable,
   output wire timer0Tick,
   output wire timer1Tick,
   output wire [3:0] irqRequest,
   output wire [3:0] waveformModeSelect,
   output wire prescalerResetActive
);
   // flag vector order: 3 capture, 2 compare b, 1 compare a, 0 overflow
   reg [3:0] flags_ff;
   reg [3:0] nxt_flags;
   reg [3:0] mask_ff;
   reg [3:0] irq_ff;
   reg syncMode_ff;
   reg nxt_syncMode;
   reg psr_ff;
   reg nxt_psr;
   reg [2:0] clkSel0_ff;
   reg [2:0] clkSel1_ff;
   reg [3:0] wave_ff;
   reg [`TMPC_PRESCALE_W-1:0] prescale_ff;
   reg [`TMPC_DATA_W-1:0] rdData_ff;
   reg [`TMPC_DATA_W-1:0] rdMux;
   reg [3:0] setVec;
   reg [3:0] clrVec;
   reg ovfCond;
   reg capAtTop;

   wire [3:0] prescaleTap;
   wire rise0;
   wire fall0;
   wire rise1;
   wire fall1;
   wire wrFlags;
   wire wrMask;
   wire wrSync;
   wire wrSel0;
   wire wrSel1;
   wire wrWave;
   wire [3:0] wrFlagBits;

   assign wrFlags = regWrEn & (regAddr == `TMPC_REG_FLAGS);
   assign wrMask = regWrEn & (regAddr == `TMPC_REG_MASK);
   assign wrSync = regWrEn & (regAddr == `TMPC_REG_SYNC);
   assign wrSel0 = regWrEn & (regAddr == `TMPC_REG_CLKSEL0);
   assign wrSel1 = regWrEn & (regAddr == `TMPC_REG_CLKSEL1);
   assign wrWave = regWrEn & (regAddr == `TMPC_REG_WAVE);

   assign wrFlagBits = {regWrData[`TMPC_BIT_CAPTURE],
                        regWrData[`TMPC_BIT_CMPB],
                        regWrData[`TMPC_BIT_CMPA],
                        regWrData[`TMPC_BIT_OVF]};

   // prescaler reset control
   always @* begin
      nxt_syncMode = syncMode_ff;
      nxt_psr = psr_ff;
      if (wrSync) begin
         nxt_syncMode = regWrData[`TMPC_BIT_SYNCMODE];
         // RL17: value written is kept
         nxt_psr = regWrData[`TMPC_BIT_PSR];
      end else if (!syncMode_ff) begin
         // RL19: self clear after one cycle
         // RL18: sync mode off clears reset
         nxt_psr = 1'b0;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         syncMode_ff <= 1'b0;
         psr_ff <= 1'b0;
      end else begin
         syncMode_ff <= nxt_syncMode;
         psr_ff <= nxt_psr;
      end
   end

   // RL9: free running shared prescaler
   // RL10: not reset by clock select
   // RL19: held while reset bit set
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         prescale_ff <= `TMPC_RST_PRESCALE;
      end else if (psr_ff) begin
         prescale_ff <= `TMPC_RST_PRESCALE;
      end else begin
         prescale_ff <= prescale_ff + {{(`TMPC_PRESCALE_W-1){1'b0}}, 1'b1};
      end
   end

   // RL8: divide by 8, 64, 256, 1024
   assign prescaleTap[0] = &prescale_ff[`TMPC_TAP8_BITS-1:0];
   assign prescaleTap[1] = &prescale_ff[`TMPC_TAP64_BITS-1:0];
   assign prescaleTap[2] = &prescale_ff[`TMPC_TAP256_BITS-1:0];
   assign prescaleTap[3] = &prescale_ff[`TMPC_TAP1024_BITS-1:0];

   // control registers
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         mask_ff <= `TMPC_RST_FLAGS;
         clkSel0_ff <= `TMPC_RST_CLKSEL;
         clkSel1_ff <= `TMPC_RST_CLKSEL;
         wave_ff <= `TMPC_RST_WAVE;
      end else begin
         if (wrMask) begin
            mask_ff <= wrFlagBits;
         end
         if (wrSel0) begin
            clkSel0_ff <= regWrData[2:0];
         end
         if (wrSel1) begin
            clkSel1_ff <= regWrData[2:0];
         end
         if (wrWave) begin
            wave_ff <= regWrData[3:0];
         end
      end
   end

   // RL13: sync plus detect plus tick register
   tmpc_pin_edge u_edge0 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pinIn(extClkPin0),
      .edgeRise(rise0),
      .edgeFall(fall0)
   );

   tmpc_pin_edge u_edge1 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pinIn(extClkPin1),
      .edgeRise(rise1),
      .edgeFall(fall1)
   );

   // RL9: independent selection per timer
   // RL17: timers halted during prescaler reset
   tmpc_clock_select u_sel0 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clockSelect(clkSel0_ff),
      .prescaleTap(prescaleTap),
      .extRise(rise0),
      .extFall(fall0),
      .halt(psr_ff),
      .timerTick(timer0Tick)
   );

   tmpc_clock_select u_sel1 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clockSelect(clkSel1_ff),
      .prescaleTap(prescaleTap),
      .extRise(rise1),
      .extFall(fall1),
      .halt(psr_ff),
      .timerTick(timer1Tick)
   );

   // overflow condition by waveform mode
   always @* begin
      case (wave_ff)
         4'h0, 4'h4, 4'hc: begin
            ovfCond = counterAtMax;
         end
         4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
            ovfCond = counterAtTop;
         end
         default: begin
            ovfCond = counterAtBottom;
         end
      endcase
   end

   // capture register used as top
   always @* begin
      case (wave_ff)
         `TMPC_WAVE_PFC_CAP, `TMPC_WAVE_PC_CAP,
         `TMPC_WAVE_CTC_CAP, `TMPC_WAVE_FAST_CAP: begin
            capAtTop = 1'b1;
         end
         default: begin
            capAtTop = 1'b0;
         end
      endcase
   end

   // flag set and clear terms
   always @* begin
      setVec = 4'h0;
      // RL1: capture pin or top
      if (capAtTop) begin
         setVec[3] = timer1Tick & counterAtTop;
      end else begin
         setVec[3] = captureEvent;
      end
      // RL3: set on the tick leaving a match
      // RL4: only counter equality sets these
      setVec[2] = timer1Tick & compareBEqual;
      setVec[1] = timer1Tick & compareAEqual;
      // RL5: mode dependent overflow
      setVec[0] = timer1Tick & ovfCond;
      // RL2: vector or write one
      // RL22: zero bits leave flags alone
      clrVec = vectorAck | (wrFlags ? wrFlagBits : 4'h0);
      // set wins over a same cycle clear
      nxt_flags = (flags_ff & ~clrVec) | setVec;
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         flags_ff <= `TMPC_RST_FLAGS;
         irq_ff <= `TMPC_RST_FLAGS;
      end else begin
         flags_ff <= nxt_flags;
         // RL21: flag, mask and global enable
         irq_ff <= flags_ff & mask_ff & {4{globalIntEnable}};
      end
   end

   // read mux, reserved bits read zero
   always @* begin
      rdMux = `TMPC_RST_BYTE;
      case (regAddr)
         `TMPC_REG_FLAGS: begin
            rdMux[`TMPC_BIT_CAPTURE] = flags_ff[3];
            rdMux[`TMPC_BIT_CMPB] = flags_ff[2];
            rdMux[`TMPC_BIT_CMPA] = flags_ff[1];
            rdMux[`TMPC_BIT_OVF] = flags_ff[0];
         end
         `TMPC_REG_MASK: begin
            rdMux[`TMPC_BIT_CAPTURE] = mask_ff[3];
            rdMux[`TMPC_BIT_CMPB] = mask_ff[2];
            rdMux[`TMPC_BIT_CMPA] = mask_ff[1];
            rdMux[`TMPC_BIT_OVF] = mask_ff[0];
         end
         `TMPC_REG_SYNC: begin
            rdMux[`TMPC_BIT_SYNCMODE] = syncMode_ff;
            rdMux[`TMPC_BIT_PSR] = psr_ff;
         end
         `TMPC_REG_CLKSEL0: begin
            rdMux[2:0] = clkSel0_ff;
         end
         `TMPC_REG_CLKSEL1: begin
            rdMux[2:0] = clkSel1_ff;
         end
         `TMPC_REG_WAVE: begin
            rdMux[3:0] = wave_ff;
         end
         `TMPC_REG_PRESCALE: begin
            rdMux = prescale_ff[`TMPC_DATA_W-1:0];
         end
         default: begin
            rdMux = `TMPC_RST_BYTE;
         end
      endcase
   end

   // read data valid only in the cycle after the strobe
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rdData_ff <= `TMPC_RST_BYTE;
      end else if (regRdEn) begin
         rdData_ff <= rdMux;
      end else begin
         rdData_ff <= `TMPC_RST_BYTE;
      end
   end

   assign regRdData = rdData_ff;
   assign irqRequest = irq_ff;
   assign waveformModeSelect = wave_ff;
   assign prescalerResetActive = psr_ff;
endmodule

// >>> verif/tmpc_checker.sv
// port checker for the prescaler, clock select and flag block
`timescale 1ns/1ps
`include "tmpc_consts.vh"
module tmpc_checker (
   input wire sys_clk,
   input wire sys_rst,
   input wire [`TMPC_ADDR_W-1:0] regAddr,
   input wire [`TMPC_DATA_W-1:0] regWrData,
   input wire regWrEn,
   input wire regRdEn,
   input wire [`TMPC_DATA_W-1:0] regRdData,
   input wire counterAtMax,
   input wire counterAtTop,
   input wire counterAtBottom,
   input wire [3:0] vectorAck,
   input wire globalIntEnable,
   input wire timer0Tick,
   input wire timer1Tick,
   input wire [3:0] irqRequest,
   input wire [3:0] waveformModeSelect,
   input wire prescalerResetActive
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire syncWr = regWrEn && regAddr == `TMPC_REG_SYNC;
   property p_rsv_zero;
      regRdEn && regAddr == `TMPC_REG_FLAGS |=> (regRdData & 8'hd8) == 8'h00;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved flag bits read set");
   property p_psr_set;
      syncWr && regWrData[0] |=> prescalerResetActive;
   endproperty
   a_psr_set: assert property (p_psr_set) else $error("prescaler reset not taken");
   property p_psr_pulse;
      syncWr && regWrData == 8'h01 ##1 !regWrEn |=> !prescalerResetActive;
   endproperty
   a_psr_pulse: assert property (p_psr_pulse) else $error("prescaler reset did not self clear");
   property p_psr_hold;
      syncWr && regWrData == 8'h81 ##1 (!regWrEn) [*4] |-> prescalerResetActive;
   endproperty
   a_psr_hold: assert property (p_psr_hold) else $error("sync mode lost prescaler reset");
   property p_psr_clr;
      syncWr && !regWrData[7] && !regWrData[0] |=> !prescalerResetActive;
   endproperty
   a_psr_clr: assert property (p_psr_clr) else $error("prescaler reset kept after sync off");
   property p_halt;
      prescalerResetActive && $past(prescalerResetActive) |-> !timer0Tick && !timer1Tick;
   endproperty
   a_halt: assert property (p_halt) else $error("tick during prescaler reset");
   property p_gie;
      !$past(globalIntEnable) |-> irqRequest == 4'h0;
   endproperty
   a_gie: assert property (p_gie) else $error("request without global enable");
   property p_wave;
      regWrEn && regAddr == `TMPC_REG_WAVE |=> waveformModeSelect == $past(regWrData[3:0]);
   endproperty
   a_wave: assert property (p_wave) else $error("waveform mode not stored");
   property p_ack;
      vectorAck[0] && !counterAtMax && !counterAtTop && !counterAtBottom |-> ##2 !irqRequest[0];
   endproperty
   a_ack: assert property (p_ack) else $error("overflow request kept after vector");
endmodule
bind tmpc_top tmpc_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
   .counterAtMax(counterAtMax), .counterAtTop(counterAtTop), .counterAtBottom(counterAtBottom),
   .vectorAck(vectorAck), .globalIntEnable(globalIntEnable), .timer0Tick(timer0Tick),
   .timer1Tick(timer1Tick), .irqRequest(irqRequest), .waveformModeSelect(waveformModeSelect),
   .prescalerResetActive(prescalerResetActive));

// >>> verif/tmpc_top_bench.sv
// self-checking bench for the prescaler, clock select and flag block
`timescale 1ns/1ps
`include "tmpc_consts.vh"
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin failures++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tmpc_top_bench;
   reg sys_clk = 1'b0;
   reg sys_rst = 1'b1;
   reg [3:0] regAddr = 4'h0;
   reg [7:0] regWrData = 8'h00;
   reg regWrEn = 1'b0;
   reg regRdEn = 1'b0;
   reg extClkPin0 = 1'b0;
   reg extClkPin1 = 1'b0;
   reg [3:0] cond = 4'h0;
   reg counterAtTop = 1'b0;
   reg [3:0] vectorAck = 4'h0;
   reg globalIntEnable = 1'b0;
   reg [7:0] rdv;
   wire [7:0] regRdData;
   wire timer0Tick, timer1Tick, prescalerResetActive;
   wire [3:0] irqRequest, waveformModeSelect;
   integer failures = 0, compares = 0, t0cnt = 0, t1cnt = 0, flagsExp = 0, i, n, f, g, seedTmp;
   integer psCnt = 0;
   tmpc_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .extClkPin0(extClkPin0),
      .extClkPin1(extClkPin1), .captureEvent(cond[3]), .compareAEqual(cond[0]), .compareBEqual(cond[1]),
      .counterAtMax(cond[2]), .counterAtTop(counterAtTop), .counterAtBottom(1'b0), .vectorAck(vectorAck),
      .globalIntEnable(globalIntEnable), .timer0Tick(timer0Tick), .timer1Tick(timer1Tick),
      .irqRequest(irqRequest), .waveformModeSelect(waveformModeSelect),
      .prescalerResetActive(prescalerResetActive));
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (timer0Tick === 1'b1) t0cnt <= t0cnt + 1;
      if (timer1Tick === 1'b1) t1cnt <= t1cnt + 1;
   end
   // free running prescaler model
   always @(posedge sys_clk) begin
      if (sys_rst) psCnt <= 0;
      else psCnt <= psCnt + 1;
   end
   task cyc(input integer k);
      begin
         repeat (k) @(posedge sys_clk);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge sys_clk);
         regAddr <= a;
         regWrData <= d;
         regWrEn <= 1'b1;
         @(posedge sys_clk);
         regWrEn <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, output [7:0] d);
      begin
         @(posedge sys_clk);
         regAddr <= a;
         regRdEn <= 1'b1;
         @(posedge sys_clk);
         regRdEn <= 1'b0;
         #1;
         d = regRdData;
      end
   endtask
   task gap(output integer fc, output integer gc);
      begin
         fc = 0;
         do begin @(posedge sys_clk); #1; fc = fc + 1; end while (timer0Tick !== 1'b1 && fc < 3000);
         gc = 0;
         do begin @(posedge sys_clk); #1; gc = gc + 1; end while (timer0Tick !== 1'b1 && gc < 3000);
      end
   endtask
   task pulses(input [2:0] sel, input integer k);
      begin
         wr(`TMPC_REG_CLKSEL1, {5'h00, sel});
         cyc(2);
         t1cnt = 0;
         repeat (k) begin
            @(posedge sys_clk);
            extClkPin1 <= 1'b1;
            cyc(3);
            @(posedge sys_clk);
            extClkPin1 <= 1'b0;
            cyc(3);
         end
         cyc(6);
         `CHK("edge ticks", k, t1cnt)
      end
   endtask
   task hit(input integer j);
      begin
         @(posedge sys_clk);
         cond[j] <= 1'b1;
         @(posedge sys_clk);
         cond[j] <= 1'b0;
         cyc(2);
         flagsExp = flagsExp | ((j == 0) ? 2 : (j == 1) ? 4 : (j == 2) ? 1 : 32);
         rd(`TMPC_REG_FLAGS, rdv);
         `CHK("flags", flagsExp, rdv)
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", compares, failures);
         if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask
   initial begin
      #100000;
      failures = failures + 1;
      end_sim;
   end
   initial begin
      seedTmp = $urandom(32'h162899a6);
      cyc(2);
      sys_rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         rd(i[3:0], rdv);
         `CHK("reset value", ((i == 6) ? ((psCnt - 1) & 255) : 0), rdv)
      end
      wr(`TMPC_REG_CLKSEL1, 8'h01);
      cyc(3);
      t1cnt = 0;
      cyc(16);
      `CHK("direct ticks", 16, t1cnt)
      t0cnt = 0;
      cyc(40);
      `CHK("stopped ticks", 0, t0cnt)
      for (i = 2; i <= 5; i = i + 1) begin
         n = (i == 2) ? 8 : (i == 3) ? 64 : (i == 4) ? 256 : 1024;
         wr(`TMPC_REG_CLKSEL0, i[7:0]);
         gap(f, g);
         `CHK("first count", 1, (f >= 1 && f <= n + 1))
         `CHK("tap period", n, g)
         wr(`TMPC_REG_CLKSEL0, 8'h00);
      end
      wr(`TMPC_REG_SYNC, 8'h81);
      cyc(2);
      t1cnt = 0;
      cyc(20);
      `CHK("held ticks", 0, t1cnt)
      wr(`TMPC_REG_SYNC, 8'h00);
      cyc(3);
      t1cnt = 0;
      cyc(8);
      `CHK("resumed ticks", 8, t1cnt)
      wr(`TMPC_REG_SYNC, 8'h01);
      cyc(3);
      rd(`TMPC_REG_SYNC, rdv);
      `CHK("reset bit", 0, rdv)
      wr(`TMPC_REG_CLKSEL1, 8'h07);
      @(posedge sys_clk);
      extClkPin1 <= 1'b1;
      f = 0;
      do begin @(posedge sys_clk); #1; f = f + 1; end while (timer1Tick !== 1'b1 && f < 10);
      `CHK("edge latency", 1, (f >= 3 && f <= 4))
      @(posedge sys_clk);
      extClkPin1 <= 1'b0;
      cyc(4);
      pulses(3'h6, $urandom_range(8, 1));
      pulses(3'h7, $urandom_range(8, 1));
      wr(`TMPC_REG_CLKSEL0, 8'h07);
      cyc(2);
      t0cnt = 0;
      @(posedge sys_clk);
      extClkPin0 <= 1'b1;
      cyc(6);
      @(posedge sys_clk);
      extClkPin0 <= 1'b0;
      cyc(6);
      `CHK("pin0 ticks", 1, t0cnt)
      wr(`TMPC_REG_CLKSEL0, 8'h00);
      wr(`TMPC_REG_CLKSEL1, 8'h01);
      wr(`TMPC_REG_MASK, 8'h27);
      @(posedge sys_clk);
      globalIntEnable <= 1'b1;
      for (i = 0; i < 4; i = i + 1) hit(i);
      `CHK("requests", 4'hf, irqRequest)
      wr(`TMPC_REG_FLAGS, 8'h00);
      rd(`TMPC_REG_FLAGS, rdv);
      `CHK("zero write", flagsExp, rdv)
      wr(`TMPC_REG_FLAGS, 8'h02);
      flagsExp = flagsExp & 32'hfd;
      rd(`TMPC_REG_FLAGS, rdv);
      `CHK("one write", flagsExp, rdv)
      @(posedge sys_clk);
      vectorAck <= 4'h1;
      @(posedge sys_clk);
      vectorAck <= 4'h0;
      flagsExp = flagsExp & 32'hfe;
      cyc(2);
      `CHK("requests after vector", 4'hc, irqRequest)
      @(posedge sys_clk);
      globalIntEnable <= 1'b0;
      cyc(2);
      `CHK("masked requests", 4'h0, irqRequest)
      wr(`TMPC_REG_FLAGS, 8'h24);
      wr(`TMPC_REG_WAVE, 8'h0c);
      @(posedge sys_clk);
      counterAtTop <= 1'b1;
      @(posedge sys_clk);
      counterAtTop <= 1'b0;
      cyc(2);
      rd(`TMPC_REG_FLAGS, rdv);
      `CHK("capture at top", 32'h20, rdv)
      end_sim;
   end
endmodule
